/* hw/fcd_pkg.sv */
// Contract
// - Readable; bits 6..0 write-once, bit 7 read-only
// - Loaded flag reads 1 after first write
// - Select bit adds divide-by-8 prescale
// - Overall divide ratio reaches 512, never more
package fcd_pkg;

  // ----------------------------------------------------------------
  // Bus geometry
  // ----------------------------------------------------------------
  localparam int FCD_ADDR_W = 12;  // Byte address width of the slave
  localparam int FCD_DATA_W = 32;  // AXI4-Lite data width

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [11:0] FCD_DIV_OFFSET = 12'h000;

  // Field positions inside flash_timebase_divider
  localparam int FCD_LOADED_BIT = 7;
  localparam int FCD_SELECT_BIT = 6;
  localparam int FCD_FIELD_W = 6;  // divider_ratio_field is bits 5..0
  localparam int FCD_WRITABLE_W = 7;  // Bits 6..0 take the one write

  // Reset values
  localparam logic [6:0] FCD_WRITABLE_RESET = 7'h00;
  localparam logic FCD_LOADED_RESET = 1'b0;

  // ----------------------------------------------------------------
  // Division figures
  // ----------------------------------------------------------------
  localparam int FCD_PRESCALE_RATIO = 8;
  localparam int FCD_MAX_RATIO = 512;

  // ----------------------------------------------------------------
  // Bus response codes
  // ----------------------------------------------------------------
  localparam logic [1:0] FCD_RESP_OKAY = 2'h0;
  localparam logic [1:0] FCD_RESP_SLVERR = 2'h2;

endpackage

/* hw/fcd_prescaler.sv */
`timescale 1ns/1ps
// Optional divide-by-8 ahead of the ratio divider, as a tick stream
module fcd_prescaler (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic select,
  output logic pre_tick
);

  // ----------------------------------------------------------------
  // Phase counter
  // ----------------------------------------------------------------
  logic [2:0] phase;  // Oscillator cycles within one prescaled period
  logic [2:0] next_phase;
  localparam logic [2:0] LAST_PHASE =
    3'(fcd_pkg::FCD_PRESCALE_RATIO - 1);

  always_comb begin
    next_phase = 3'h0;
    if (run && select) begin
      next_phase = (phase == LAST_PHASE) ? 3'h0 : phase + 3'h1;
    end
  end

  // Registered only; the counter idles at zero while stopped
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      phase <= 3'h0;
    end else begin
      phase <= next_phase;
    end
  end

  assign pre_tick = run && (!select || phase == LAST_PHASE);

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  prescale_gap_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (pre_tick && select) |=> !pre_tick [*7] ##1 pre_tick)
    else $error("prescaled tick spacing is not eight cycles");

  direct_feed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (run && !select) |-> pre_tick)
    else $error("direct feed missed an oscillator cycle");

  prescale_seen_c: cover property (@(posedge aclk) disable iff (!aresetn)
    pre_tick && select);

endmodule

/* hw/fcd_ratio_divider.sv */
`timescale 1ns/1ps
// Divides the prescaled tick stream by the ratio field plus one
module fcd_ratio_divider (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic run,
  input wire logic pre_tick,
  input wire logic [5:0] ratio_field,
  output logic out_tick
);

  // ----------------------------------------------------------------
  // Ratio counter
  // ----------------------------------------------------------------
  logic [5:0] count;  // Prescaled ticks seen in this period
  logic [5:0] next_count;
  logic next_out_tick;

  always_comb begin
    next_count = count;
    next_out_tick = 1'b0;
    if (!run) begin
      next_count = 6'h00;
    end else if (pre_tick) begin
      if (count == ratio_field) begin
        next_count = 6'h00;
        next_out_tick = 1'b1;
      end else begin
        next_count = count + 6'h01;
      end
    end
  end

  // Output is a flop so the timebase carries no decode glitches
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      count <= 6'h00;
      out_tick <= 1'b0;
    end else begin
      count <= next_count;
      out_tick <= next_out_tick;
    end
  end

  // ----------------------------------------------------------------
  // Check helper: prescaled ticks between two output ticks
  // ----------------------------------------------------------------
  logic [6:0] seen;
  logic primed;  // First period after start is not measured
  always_ff @(posedge aclk) begin
    if (!aresetn || !run) begin
      seen <= 7'h00;
      primed <= 1'b0;
    end else begin
      seen <= out_tick ? 7'(pre_tick) : seen + 7'(pre_tick);
      primed <= primed | out_tick;
    end
  end

  ratio_period_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (out_tick && primed) |-> seen == 7'(ratio_field) + 7'h01)
    else $error("timebase period differs from field plus one");

endmodule

/* hw/fcd_flash_clock_divider.sv */
`timescale 1ns/1ps
// Flash timebase divider with its write-once control register
module fcd_flash_clock_divider (
  input wire logic aclk,
  input wire logic aresetn,
  // AXI4-Lite write address
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [11:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  // AXI4-Lite write data
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  // AXI4-Lite write response
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  output logic [1:0] s_axi_bresp,
  // AXI4-Lite read address
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  input wire logic [11:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  // AXI4-Lite read data
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  // Flash side
  output logic timebase_tick,
  output logic divider_loaded_flag
);

  // ----------------------------------------------------------------
  // Divider register state
  // ----------------------------------------------------------------
  logic [6:0] writable;  // Select bit and ratio field
  logic [6:0] next_writable;
  logic next_loaded;
  logic prescale_by_eight_select;
  logic [5:0] divider_ratio_field;

  assign prescale_by_eight_select = writable[fcd_pkg::FCD_SELECT_BIT];
  assign divider_ratio_field = writable[fcd_pkg::FCD_FIELD_W-1:0];

  // ----------------------------------------------------------------
  // Write channel capture
  // ----------------------------------------------------------------
  logic aw_held;  // Address taken, waiting for data or response
  logic [11:0] aw_addr;
  logic w_held;  // Data taken, waiting for address or response
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic next_aw_held;
  logic [11:0] next_aw_addr;
  logic next_w_held;
  logic [31:0] next_w_data;
  logic [3:0] next_w_strb;
  logic next_bvalid;
  logic [1:0] next_bresp;
  logic wr_commit;  // Both halves present: act on the write now
  logic wr_hit;  // Write lands on the divider register
  logic wr_lane0;  // Byte lane holding the register is enabled

  // Channels accept independently; nothing new until the answer drains
  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready = !w_held && !s_axi_bvalid;
  assign wr_commit = aw_held && w_held && !s_axi_bvalid;
  assign wr_hit = (aw_addr[11:2] == fcd_pkg::FCD_DIV_OFFSET[11:2]);
  assign wr_lane0 = w_strb[0];

  // Next values for the write path
  always_comb begin
    next_aw_held = aw_held;
    next_aw_addr = aw_addr;
    next_w_held = w_held;
    next_w_data = w_data;
    next_w_strb = w_strb;
    next_bvalid = s_axi_bvalid;
    next_bresp = s_axi_bresp;
    // Address handshake
    if (s_axi_awvalid && s_axi_awready) begin
      next_aw_held = 1'b1;
      next_aw_addr = s_axi_awaddr;
    end
    // Data handshake
    if (s_axi_wvalid && s_axi_wready) begin
      next_w_held = 1'b1;
      next_w_data = s_axi_wdata;
      next_w_strb = s_axi_wstrb;
    end
    // Commit raises the response and frees both holders
    if (wr_commit) begin
      next_aw_held = 1'b0;
      next_w_held = 1'b0;
      next_bvalid = 1'b1;
      // Unmapped words answer an error; the write is dropped
      next_bresp = wr_hit ? fcd_pkg::FCD_RESP_OKAY
                          : fcd_pkg::FCD_RESP_SLVERR;
    end else if (s_axi_bvalid && s_axi_bready) begin
      next_bvalid = 1'b0;
    end
  end

  // Write path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= 12'h000;
      w_held <= 1'b0;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= 2'h0;
    end else begin
      aw_held <= next_aw_held;
      aw_addr <= next_aw_addr;
      w_held <= next_w_held;
      w_data <= next_w_data;
      w_strb <= next_w_strb;
      s_axi_bvalid <= next_bvalid;
      s_axi_bresp <= next_bresp;
    end
  end

  // ----------------------------------------------------------------
  // Divider register update
  // ----------------------------------------------------------------
  // A write with lane 0 off stores nothing and so does not count as the
  // one write; the flash timing stays unloaded until a real one lands.
  always_comb begin
    next_writable = writable;
    next_loaded = divider_loaded_flag;
    if (wr_commit && wr_hit && wr_lane0 && !divider_loaded_flag) begin
      next_writable = w_data[fcd_pkg::FCD_WRITABLE_W-1:0];
      next_loaded = 1'b1;
    end
  end

  // Register storage; bit 7 has no write path at all
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      writable <= fcd_pkg::FCD_WRITABLE_RESET;
      divider_loaded_flag <= fcd_pkg::FCD_LOADED_RESET;
    end else begin
      writable <= next_writable;
      divider_loaded_flag <= next_loaded;
    end
  end

  // ----------------------------------------------------------------
  // Read channel
  // ----------------------------------------------------------------
  logic next_rvalid;
  logic [31:0] next_rdata;
  logic [1:0] next_rresp;
  logic rd_hit;
  logic [7:0] reg_view;  // Whole register as software sees it

  // One read in flight; a new address waits for the data to drain
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_hit = (s_axi_araddr[11:2] == fcd_pkg::FCD_DIV_OFFSET[11:2]);
  assign reg_view = {divider_loaded_flag, writable};

  // Next values for the read path
  always_comb begin
    next_rvalid = s_axi_rvalid;
    next_rdata = s_axi_rdata;
    next_rresp = s_axi_rresp;
    if (s_axi_arvalid && s_axi_arready) begin
      next_rvalid = 1'b1;
      if (rd_hit) begin
        next_rdata = {24'h000000, reg_view};
        next_rresp = fcd_pkg::FCD_RESP_OKAY;
      end else begin
        next_rdata = 32'h0000_0000;
        next_rresp = fcd_pkg::FCD_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      next_rvalid = 1'b0;
    end
  end

  // Read path registers
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= 2'h0;
    end else begin
      s_axi_rvalid <= next_rvalid;
      s_axi_rdata <= next_rdata;
      s_axi_rresp <= next_rresp;
    end
  end

  // ----------------------------------------------------------------
  // Timebase chain
  // ----------------------------------------------------------------
  logic pre_tick;  // Oscillator or oscillator/8 tick

  // Held off until loaded so flash timing never runs on a default ratio
  // prescaler ahead of divider
  fcd_prescaler u_prescaler (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(divider_loaded_flag),
    .select(prescale_by_eight_select),
    .pre_tick(pre_tick)
  );

  fcd_ratio_divider u_ratio_divider (
    .aclk(aclk),
    .aresetn(aresetn),
    .run(divider_loaded_flag),
    .pre_tick(pre_tick),
    .ratio_field(divider_ratio_field),
    .out_tick(timebase_tick)
  );

  // ----------------------------------------------------------------
  // Check helper: oscillator cycles since the last timebase tick
  // ----------------------------------------------------------------
  logic [9:0] since_tick;
  logic loaded_q;  // Flag one cycle late; the load edge acts as a tick

  // Counting restarts one cycle after loading, as it does after a tick,
  // so the first period is judged the same way as all later ones
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      loaded_q <= 1'b0;
    end else begin
      loaded_q <= divider_loaded_flag;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn || !loaded_q || timebase_tick) begin
      since_tick <= 10'h000;
    end else begin
      since_tick <= since_tick + 10'h001;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  write_once_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (divider_loaded_flag && wr_commit) |=> $stable(writable))
    else $error("divider register changed after its first write");

  read_back_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (s_axi_arvalid && s_axi_arready && rd_hit)
      |=> s_axi_rvalid && s_axi_rdata[7:0] == $past(reg_view))
    else $error("read data does not match the divider register");

  loaded_flag_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!divider_loaded_flag && wr_commit && wr_hit && wr_lane0)
      |=> divider_loaded_flag
          && writable == 7'($past(w_data)))
    else $error("first write did not load the register and flag");

  flag_sticky_a: assert property (@(posedge aclk) disable iff (!aresetn)
    divider_loaded_flag |=> divider_loaded_flag)
    else $error("loaded flag dropped without reset");

  max_ratio_a: assert property (@(posedge aclk) disable iff (!aresetn)
    since_tick < 10'(fcd_pkg::FCD_MAX_RATIO))
    else $error("timebase period exceeds the largest ratio");

  idle_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !divider_loaded_flag |-> !timebase_tick)
    else $error("timebase ticked before the register was loaded");

  unmapped_write_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (wr_commit && !wr_hit)
      |=> s_axi_bvalid && s_axi_bresp == fcd_pkg::FCD_RESP_SLVERR)
    else $error("unmapped write did not answer an error");

  upper_zero_a: assert property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h000000)
    else $error("read data has bits set above the register");

  lane_skip_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (!divider_loaded_flag && wr_commit && !(wr_hit && wr_lane0))
      |=> !divider_loaded_flag)
    else $error("a write that stored nothing set the loaded flag");

  first_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    !divider_loaded_flag ##1 divider_loaded_flag);

  late_write_c: cover property (@(posedge aclk) disable iff (!aresetn)
    divider_loaded_flag && wr_commit && wr_hit);

  slowest_c: cover property (@(posedge aclk) disable iff (!aresetn)
    timebase_tick && writable == 7'h7F
      && since_tick == 10'(fcd_pkg::FCD_MAX_RATIO - 1));

  unmapped_c: cover property (@(posedge aclk) disable iff (!aresetn)
    s_axi_rvalid && s_axi_rresp == fcd_pkg::FCD_RESP_SLVERR);

endmodule

/* tb/fcd_tb.sv */
`timescale 1ns/1ps
module tb;
  // ----------------------------------------------------------------
  // Clock, reset and bus signals
  // ----------------------------------------------------------------
  logic aclk = 1'b0;  // 200 MHz system clock
  logic aresetn = 1'b0;  // Synchronous, active low
  logic s_axi_awvalid = 1'b0;
  logic s_axi_awready;
  logic [11:0] s_axi_awaddr = 12'h000;
  logic s_axi_wvalid = 1'b0;
  logic s_axi_wready;
  logic [31:0] s_axi_wdata = 32'h0000_0000;
  logic [3:0] s_axi_wstrb = 4'h0;
  logic s_axi_bvalid;
  logic s_axi_bready = 1'b0;
  logic [1:0] s_axi_bresp;
  logic s_axi_arvalid = 1'b0;
  logic s_axi_arready;
  logic [11:0] s_axi_araddr = 12'h000;
  logic s_axi_rvalid;
  logic s_axi_rready = 1'b0;
  logic [31:0] s_axi_rdata;
  logic [1:0] s_axi_rresp;
  logic timebase_tick;
  logic divider_loaded_flag;
  int num_errors = 0;  // Mismatches seen
  int checks_done = 0;  // Comparisons made

  fcd_flash_clock_divider i_dut (
    .aclk(aclk), .aresetn(aresetn),
    .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
    .s_axi_awaddr(s_axi_awaddr), .s_axi_awprot(3'h0),
    .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready),
    .s_axi_wdata(s_axi_wdata), .s_axi_wstrb(s_axi_wstrb),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready),
    .s_axi_bresp(s_axi_bresp),
    .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
    .s_axi_araddr(s_axi_araddr), .s_axi_arprot(3'h0),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready),
    .s_axi_rdata(s_axi_rdata), .s_axi_rresp(s_axi_rresp),
    .timebase_tick(timebase_tick),
    .divider_loaded_flag(divider_loaded_flag)
  );

  // Free-running clock, 5 ns period
  initial begin
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  // Compare and count; an unknown never matches
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (got !== exp) begin
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
      num_errors++;
    end
  endtask

  // Reset held for six edges, then one quiet edge
  task automatic do_reset();
    aresetn <= 1'b0;
    repeat (6) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
  endtask

  // Each request starts just after a rising edge; ready is looked at
  // mid-cycle, so the next rising edge is the one of the handshake
  task automatic axi_write(input logic [11:0] addr, input logic [31:0] data,
                           input logic [3:0] strb, output logic [1:0] resp);
    logic a;
    logic w;
    logic b;
    @(posedge aclk);
    s_axi_awvalid <= 1'b1;
    s_axi_awaddr <= addr;
    s_axi_wvalid <= 1'b1;
    s_axi_wdata <= data;
    s_axi_wstrb <= strb;
    s_axi_bready <= 1'b1;
    b = 1'b0;
    while (!b) begin
      @(negedge aclk);
      a = s_axi_awvalid && (s_axi_awready === 1'b1);
      w = s_axi_wvalid && (s_axi_wready === 1'b1);
      b = (s_axi_bvalid === 1'b1);
      @(posedge aclk);
      if (a) s_axi_awvalid <= 1'b0;
      if (w) s_axi_wvalid <= 1'b0;
      if (b) resp = s_axi_bresp;
    end
    s_axi_bready <= 1'b0;
  endtask

  task automatic axi_read(input logic [11:0] addr, output logic [31:0] data,
                          output logic [1:0] resp);
    logic a;
    logic r;
    @(posedge aclk);
    s_axi_arvalid <= 1'b1;
    s_axi_araddr <= addr;
    s_axi_rready <= 1'b1;
    r = 1'b0;
    while (!r) begin
      @(negedge aclk);
      a = s_axi_arvalid && (s_axi_arready === 1'b1);
      r = (s_axi_rvalid === 1'b1);
      @(posedge aclk);
      if (a) s_axi_arvalid <= 1'b0;
      if (r) begin
        data = s_axi_rdata;
        resp = s_axi_rresp;
      end
    end
    s_axi_rready <= 1'b0;
  endtask

  // Cycles between two ticks; bounded so a dead divider shows up
  task automatic tick_period(output int n);
    int k;
    k = 0;
    @(negedge aclk);
    while (timebase_tick !== 1'b1 && k < 2000) begin
      @(negedge aclk);
      k++;
    end
    n = 0;
    do begin
      @(negedge aclk);
      n++;
    end while (timebase_tick !== 1'b1 && n < 2000);
  endtask

  // ----------------------------------------------------------------
  // Scenarios
  // ----------------------------------------------------------------
  // Fresh part: register zero, flag low, timebase silent
  task automatic test_reset_state();
    logic [31:0] d;
    logic [1:0] r;
    int seen;
    axi_read(fcd_pkg::FCD_DIV_OFFSET, d, r);
    check(d, 32'h0000_0000);
    check(divider_loaded_flag, 1'b0);
    seen = 0;
    repeat (600) begin
      @(negedge aclk);
      if (timebase_tick !== 1'b0) seen++;
    end
    check(seen, 0);
  endtask

  // Unmapped word and a write with lane 0 off store nothing
  task automatic test_refusals();
    logic [31:0] d;
    logic [1:0] r;
    axi_write(12'h004, 32'h0000_007F, 4'hF, r);
    check(r, fcd_pkg::FCD_RESP_SLVERR);
    axi_read(12'h004, d, r);
    check(r, fcd_pkg::FCD_RESP_SLVERR);
    check(d, 32'h0000_0000);
    axi_write(fcd_pkg::FCD_DIV_OFFSET, 32'h0000_007F, 4'h0, r);
    check(r, fcd_pkg::FCD_RESP_OKAY);
    axi_read(fcd_pkg::FCD_DIV_OFFSET, d, r);
    check(d, 32'h0000_0000);
    check(divider_loaded_flag, 1'b0);
  endtask

  // First write sticks, bit 7 comes from the flag, later write ignored
  task automatic test_write_once();
    logic [31:0] d;
    logic [1:0] r;
    int n;
    axi_write(fcd_pkg::FCD_DIV_OFFSET, 32'h0000_0001, 4'h1, r);
    check(r, fcd_pkg::FCD_RESP_OKAY);
    check(divider_loaded_flag, 1'b1);
    axi_read(fcd_pkg::FCD_DIV_OFFSET, d, r);
    check(d, 32'h0000_0081);
    axi_write(fcd_pkg::FCD_DIV_OFFSET, 32'h0000_007E, 4'h1, r);
    check(r, fcd_pkg::FCD_RESP_OKAY);
    axi_read(fcd_pkg::FCD_DIV_OFFSET, d, r);
    check(d, 32'h0000_0081);
    tick_period(n);
    check(n, 2);
  endtask

  // Each setting after its own reset; covers both prescale choices and
  // both ends of the range, the slowest being 512
  task automatic test_ratios();
    logic [6:0] val [4] = '{7'h40, 7'h7F, 7'h3F, 7'h00};
    int ratio [4] = '{8, 512, 64, 1};
    logic [1:0] r;
    int n;
    for (int i = 0; i < 4; i++) begin
      @(posedge aclk);
      do_reset();
      check(divider_loaded_flag, 1'b0);
      // select and field go in one write
      axi_write(fcd_pkg::FCD_DIV_OFFSET, {25'h0, val[i]}, 4'h1, r);
      tick_period(n);
      check(n, ratio[i]);
    end
  endtask

  // ----------------------------------------------------------------
  // Run control
  // ----------------------------------------------------------------
  task automatic wrap_up();
    $display("Checks done %0d, errors %0d", checks_done, num_errors);
    if (num_errors == 0 && checks_done > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Whole run needs under 2000 cycles; far beyond that means a hang
  initial begin
    repeat (50000) @(posedge aclk);
    num_errors++;
    wrap_up();
  end

  initial begin
    do_reset();
    test_reset_state();
    test_refusals();
    test_write_once();
    test_ratios();
    wrap_up();
  end
endmodule
